/* rtl/queue_if.sv */
// Connection between the sequencer and its step queue memory
`timescale 1ns/1ps
interface queue_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [2:0] rd_addr_a;
  logic [7:0] rd_data_a;
  logic [2:0] rd_addr_b;
  logic [7:0] rd_data_b;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
    input rd_data_a, rd_data_b);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
    output rd_data_a, rd_data_b);
endinterface

/* rtl/step_queue_mem.sv */
// Step queue memory with two registered read ports and write-first bypass
`timescale 1ns/1ps
module step_queue_mem
(
  input wire logic clk_sys_i,
  queue_if.mem q
);
  logic [7:0] mem [8];
  // ==========================================================================
  // Write port
  always_ff @(posedge clk_sys_i)
  begin
    if (q.wr_en)
    begin
      mem[q.wr_addr] <= q.wr_data;
    end
  end
  // Fetch read port, new data wins on a same-address write
  always_ff @(posedge clk_sys_i)
  begin
    if (q.wr_en && q.wr_addr == q.rd_addr_a)
      q.rd_data_a <= q.wr_data;
    else
      q.rd_data_a <= mem[q.rd_addr_a];
  end
  // Bus read port
  always_ff @(posedge clk_sys_i)
  begin
    if (q.wr_en && q.wr_addr == q.rd_addr_b)
      q.rd_data_b <= q.wr_data;
    else
      q.rd_data_b <= mem[q.rd_addr_b];
  end
endmodule

/* rtl/trigger_sequencer.sv */
// Peripheral trigger sequencer: AHB-Lite registers, step engine, timers and trigger outputs
// Behaviour
// - Steps are 8-bit commands fetched from a bank of queue registers.
// - Steps wait on inputs, emit output triggers, wait on timers.
// - Two 16-bit general timers, cleared and counted together, serve the steps.
// - Two independent 16-bit loop counters serve the steps.
// - Input waits detect rising or falling edges, or high or low levels, of the chosen input.
// - Four program-controlled processor interrupt outputs.
// - Single-step mode raises an interrupt for every executed step.
// - Watchdog expiry raises an interrupt.
// - Trigger inputs from converter, pwm, compare, capture, comparator, external line.
// - Trigger outputs to watchdog, compare, capture, converter, pwm, comparator.
// - Enable bit 15 switches the step engine and trigger outputs; registers stay accessible; resets to zero.
// - Bit 13 halts the step engine, but not trigger pulse timing, while the device idles.
// - Bit 12 makes trigger steps toggle outputs, else emit one pulse.
// - Writing one to bit 10 is a software trigger; zero does nothing.
// - Bit 9 selects single-step mode.
// - Bit 8 makes limit reads return live counter values.
// - Bit 7 starts continuous execution; clearing stops it.
// - Bit 6 is set by hardware on watchdog expiry.
// - Input mode bits 1-0 affect only the wait-high and wait-low steps.
// - Bits 14, 11 and 5-2 read as zero.
// - Mode codes pick edge or level, and delay on exit or not.
// - Pulse-width code N gives pulses of N+1 module clocks.
// - Watchdog code 0 disables; 1 to 7 give 8 to 512 clocks.
`timescale 1ns/1ps
`include "trigger_sequencer_consts.svh"
module trigger_sequencer
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic idle_i,
  input wire logic adc_trig_i,
  input wire logic [2:0] pwm_trig_i,
  input wire logic [3:0] oc_trig_i,
  input wire logic [3:0] ic_trig_i,
  input wire logic [2:0] cmp_trig_i,
  input wire logic external_interrupt_line_i,
  output logic wdt_trig_o,
  output logic [3:0] oc_trig_o,
  output logic [3:0] ic_trig_o,
  output logic [3:0] adc_trig_o,
  output logic pwm_trig_o,
  output logic [1:0] cmp_trig_o,
  output logic [3:0] prog_irq_o,
  output logic step_irq_o,
  output logic watchdog_irq_o
);
  queue_if q ();
  logic ph_wr, ph_rd;
  logic [7:0] ph_addr;
  logic sequencer_enable, idle_stop, trigger_toggle_mode, single_step_enable;
  logic live_value_visibility, sequencer_run, watchdog_timeout_flag, sw_pend;
  logic [1:0] input_trigger_mode;
  logic [2:0] clk_source;
  logic [4:0] div_code, div_cnt;
  logic [3:0] pulse_width_code, pulse_cnt;
  logic [2:0] watchdog_period_code;
  logic [15:0] step_delay_limit, step_delay_counter;
  logic [1:0][15:0] timer_limit, general_timer, loop_counter_limit, loop_counter;
  logic [15:0] in_meta, in_sync, in_prev, trig_level, pulse_mask;
  logic [2:0] step_ptr;
  logic [8:0] wdt_cnt;
  trigger_sequencer_pkg::seq_state_t state;
  trigger_sequencer_pkg::step_op_t op;
  logic [3:0] arg;
  logic tick, halt, adv, exec_now, is_wait, need_delay, wait_done, sd_done;
  logic wait_exit, delay_exit, step_done, take_loop, wdt_expire, trig_load;
  logic [8:0] wdt_last;
  logic [15:0] csr_rd, sel_bit;
  logic wr_csr, wr_ctrl;

  // ==========================================================================
  // Helpers
  function automatic logic step_is_wait(input logic [7:0] cmd);
    logic [3:0] a;
    a = cmd[3:0];
    step_is_wait = (cmd[7:4] == 4'h1) || (cmd[7:4] == 4'h2) ||
      ((cmd[7:4] == 4'h0) && (a >= 4'h1) && (a <= 4'h4));
  endfunction
  function automatic logic [31:0] limit_view(input logic vis, input logic [15:0] live,
    input logic [15:0] lim);
    limit_view = {16'h0000, (vis ? live : lim)};
  endfunction

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
    end
    else if (hready_i)
    begin
      ph_wr <= hsel_i && htrans_i[1] && hwrite_i && (haddr_i[31:8] == 24'h000000);
      ph_rd <= hsel_i && htrans_i[1] && !hwrite_i && (haddr_i[31:8] == 24'h000000);
      ph_addr <= haddr_i[7:0];
    end
  end
  assign wr_csr = ph_wr && (ph_addr == `TS_OFF_CSR);
  assign wr_ctrl = ph_wr && (ph_addr == `TS_OFF_CTRL);
  // Queue words at 0x20..0x3C
  assign q.wr_en = ph_wr && (ph_addr[7:5] == `TS_QUEUE_BASE_SEL) && (ph_addr[1:0] == 2'h0);
  assign q.wr_addr = ph_addr[4:2];
  assign q.wr_data = hwdata_i[7:0];
  assign q.rd_addr_b = haddr_i[4:2];
  assign q.rd_addr_a = step_ptr;

  // Control/status readback, unused bits zero
  always_comb
  begin
    csr_rd = `TS_RST_CSR;
    csr_rd[`TS_CSR_EN] = sequencer_enable;
    csr_rd[`TS_CSR_IDLE_STOP] = idle_stop;
    csr_rd[`TS_CSR_TOGGLE] = trigger_toggle_mode;
    csr_rd[`TS_CSR_SWT] = sw_pend;
    csr_rd[`TS_CSR_SSTEP] = single_step_enable;
    csr_rd[`TS_CSR_VIS] = live_value_visibility;
    csr_rd[`TS_CSR_RUN] = sequencer_run;
    csr_rd[`TS_CSR_WDTO] = watchdog_timeout_flag;
    csr_rd[`TS_CSR_ITM_HI:`TS_CSR_ITM_LO] = input_trigger_mode;
  end

  // Read data mux in the data phase
  always_comb
  begin
    hrdata_o = 32'h00000000;
    if (ph_rd)
    begin
      if (ph_addr[7:5] == `TS_QUEUE_BASE_SEL && ph_addr[1:0] == 2'h0)
        hrdata_o = {24'h000000, q.rd_data_b};
      else
        case (ph_addr)
          `TS_OFF_CSR: hrdata_o = {16'h0000, csr_rd};
          `TS_OFF_CTRL: hrdata_o = {16'h0000, clk_source, div_code, pulse_width_code, 1'b0,
            watchdog_period_code};
          `TS_OFF_SD_LIM: hrdata_o = limit_view(live_value_visibility, step_delay_counter,
            step_delay_limit);
          `TS_OFF_T0_LIM: hrdata_o = limit_view(live_value_visibility, general_timer[0],
            timer_limit[0]);
          `TS_OFF_T1_LIM: hrdata_o = limit_view(live_value_visibility, general_timer[1],
            timer_limit[1]);
          `TS_OFF_C0_LIM: hrdata_o = limit_view(live_value_visibility, loop_counter[0],
            loop_counter_limit[0]);
          `TS_OFF_C1_LIM: hrdata_o = limit_view(live_value_visibility, loop_counter[1],
            loop_counter_limit[1]);
          `TS_OFF_STATUS: hrdata_o = {8'h00, trig_level, 3'h0, state};
          default: hrdata_o = 32'h00000000;
        endcase
    end
  end

  // ==========================================================================
  // Software-written configuration
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sequencer_enable <= 1'b0;
      idle_stop <= 1'b0;
      trigger_toggle_mode <= 1'b0;
      single_step_enable <= 1'b0;
      live_value_visibility <= 1'b0;
      input_trigger_mode <= 2'h0;
    end
    else if (wr_csr)
    begin
      sequencer_enable <= hwdata_i[`TS_CSR_EN];
      idle_stop <= hwdata_i[`TS_CSR_IDLE_STOP];
      trigger_toggle_mode <= hwdata_i[`TS_CSR_TOGGLE];
      single_step_enable <= hwdata_i[`TS_CSR_SSTEP];
      live_value_visibility <= hwdata_i[`TS_CSR_VIS];
      input_trigger_mode <= hwdata_i[`TS_CSR_ITM_HI:`TS_CSR_ITM_LO];
    end
  end
  // Clock, pulse and watchdog setup
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      {clk_source, div_code, pulse_width_code} <= 12'(`TS_RST_CTRL >> 4'h4);
      watchdog_period_code <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      clk_source <= hwdata_i[`TS_CTRL_CLK_HI:`TS_CTRL_CLK_LO];
      div_code <= hwdata_i[`TS_CTRL_DIV_HI:`TS_CTRL_DIV_LO];
      pulse_width_code <= hwdata_i[`TS_CTRL_PWD_HI:`TS_CTRL_PWD_LO];
      watchdog_period_code <= hwdata_i[`TS_CTRL_WDT_HI:`TS_CTRL_WDT_LO];
    end
  end
  // Limit registers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      step_delay_limit <= `TS_RST_LIMIT;
      timer_limit <= {`TS_RST_LIMIT, `TS_RST_LIMIT};
      loop_counter_limit <= {`TS_RST_LIMIT, `TS_RST_LIMIT};
    end
    else if (ph_wr)
    begin
      case (ph_addr)
        `TS_OFF_SD_LIM: step_delay_limit <= hwdata_i[15:0];
        `TS_OFF_T0_LIM: timer_limit[0] <= hwdata_i[15:0];
        `TS_OFF_T1_LIM: timer_limit[1] <= hwdata_i[15:0];
        `TS_OFF_C0_LIM: loop_counter_limit[0] <= hwdata_i[15:0];
        `TS_OFF_C1_LIM: loop_counter_limit[1] <= hwdata_i[15:0];
        default: step_delay_limit <= step_delay_limit;
      endcase
    end
  end

  // ==========================================================================
  // Module clock prescaler, divide by code plus one
  assign tick = (div_cnt == div_code);
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || tick)
      div_cnt <= 5'h00;
    else
      div_cnt <= div_cnt + 5'h01;
  end
  // Trigger input synchronisers, previous sample taken per module clock
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      in_meta <= 16'h0000;
      in_sync <= 16'h0000;
      in_prev <= 16'h0000;
    end
    else
    begin
      in_meta <= {external_interrupt_line_i, cmp_trig_i, ic_trig_i, oc_trig_i, pwm_trig_i,
        adc_trig_i};
      in_sync <= in_meta;
      if (tick)
        in_prev <= in_sync;
    end
  end

  // ==========================================================================
  // Step decode and wait conditions
  assign op = trigger_sequencer_pkg::step_op_t'(q.rd_data_a[7:4]);
  assign arg = q.rd_data_a[3:0];
  assign sel_bit = 16'h0001 << arg;
  assign halt = idle_stop && idle_i;
  assign adv = tick && sequencer_enable && !halt;
  assign is_wait = step_is_wait(q.rd_data_a);
  assign need_delay = (op == trigger_sequencer_pkg::OP_WAIT_HIGH ||
    op == trigger_sequencer_pkg::OP_WAIT_LOW) && !input_trigger_mode[0];
  assign sd_done = (step_delay_counter == step_delay_limit);
  always_comb
  begin
    wait_done = 1'b0;
    case (op)
      trigger_sequencer_pkg::OP_WAIT_HIGH: wait_done = input_trigger_mode[1] ?
        in_sync[arg] : (in_sync[arg] && !in_prev[arg]);
      trigger_sequencer_pkg::OP_WAIT_LOW: wait_done = input_trigger_mode[1] ?
        !in_sync[arg] : (!in_sync[arg] && in_prev[arg]);
      trigger_sequencer_pkg::OP_CTRL:
        case (arg)
          4'h1: wait_done = sw_pend;
          4'h2: wait_done = sd_done;
          4'h3: wait_done = (general_timer[0] == timer_limit[0]);
          4'h4: wait_done = (general_timer[1] == timer_limit[1]);
          default: wait_done = 1'b0;
        endcase
      default: wait_done = 1'b0;
    endcase
  end
  assign exec_now = adv && (state == trigger_sequencer_pkg::ST_EXEC);
  assign wait_exit = adv && (state == trigger_sequencer_pkg::ST_WAIT) && wait_done;
  assign delay_exit = adv && (state == trigger_sequencer_pkg::ST_DELAY) && sd_done;
  assign step_done = (exec_now && !is_wait) || (wait_exit && !need_delay) || delay_exit;
  assign take_loop = (loop_counter[arg[3]] != loop_counter_limit[arg[3]]);
  assign wdt_last = 9'((10'h001 << ({1'b0, watchdog_period_code} + `TS_WDT_SHIFT_BASE)) -
    10'h001);
  assign wdt_expire = adv && (state == trigger_sequencer_pkg::ST_WAIT) && !wait_done &&
    (watchdog_period_code != 3'h0) && (wdt_cnt == wdt_last);
  assign trig_load = exec_now && (op == trigger_sequencer_pkg::OP_TRIG);

  // ==========================================================================
  // Sequencer state machine
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !sequencer_enable || !sequencer_run || wdt_expire)
      state <= trigger_sequencer_pkg::ST_IDLE;
    else if (adv)
      case (state)
        trigger_sequencer_pkg::ST_IDLE: state <= trigger_sequencer_pkg::ST_FETCH;
        trigger_sequencer_pkg::ST_FETCH: state <= trigger_sequencer_pkg::ST_EXEC;
        trigger_sequencer_pkg::ST_EXEC:
          state <= is_wait ? trigger_sequencer_pkg::ST_WAIT : trigger_sequencer_pkg::ST_FETCH;
        trigger_sequencer_pkg::ST_WAIT:
          if (wait_done)
            state <= need_delay ? trigger_sequencer_pkg::ST_DELAY :
              trigger_sequencer_pkg::ST_FETCH;
        trigger_sequencer_pkg::ST_DELAY:
          if (sd_done)
            state <= trigger_sequencer_pkg::ST_FETCH;
        default: state <= trigger_sequencer_pkg::ST_IDLE;
      endcase
  end
  // Step pointer with loop and jump
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !sequencer_enable)
      step_ptr <= 3'h0;
    else if (step_done)
    begin
      if (exec_now && (op == trigger_sequencer_pkg::OP_JUMP ||
        (op == trigger_sequencer_pkg::OP_LOOP && take_loop)))
        step_ptr <= arg[2:0];
      else
        step_ptr <= step_ptr + 3'h1;
    end
  end
  // Loop counters
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !sequencer_enable)
      loop_counter <= {16'h0000, 16'h0000};
    else if (exec_now && op == trigger_sequencer_pkg::OP_LOOP)
      loop_counter[arg[3]] <= take_loop ? loop_counter[arg[3]] + 16'h0001 : 16'h0000;
  end
  // General timers and step delay counter
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || (adv && state == trigger_sequencer_pkg::ST_FETCH))
    begin
      general_timer <= {16'h0000, 16'h0000};
      step_delay_counter <= 16'h0000;
    end
    else if (adv && state == trigger_sequencer_pkg::ST_WAIT)
    begin
      general_timer[0] <= general_timer[0] + 16'h0001;
      general_timer[1] <= general_timer[1] + 16'h0001;
      step_delay_counter <= (wait_done && need_delay) ? 16'h0000 :
        step_delay_counter + 16'h0001;
    end
    else if (adv && state == trigger_sequencer_pkg::ST_DELAY)
      step_delay_counter <= step_delay_counter + 16'h0001;
  end
  // Watchdog counts module clocks spent waiting
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || state != trigger_sequencer_pkg::ST_WAIT)
      wdt_cnt <= 9'h000;
    else if (adv)
      wdt_cnt <= wdt_cnt + 9'h001;
  end

  // ==========================================================================
  // Hardware-touched control bits, set wins over clear
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sequencer_run <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      sw_pend <= 1'b0;
    end
    else
    begin
      if (wr_csr)
        sequencer_run <= hwdata_i[`TS_CSR_RUN];
      else if (wdt_expire || (step_done && single_step_enable))
        sequencer_run <= 1'b0;
      if (wdt_expire)
        watchdog_timeout_flag <= 1'b1;
      else if (wr_csr && !hwdata_i[`TS_CSR_WDTO])
        watchdog_timeout_flag <= 1'b0;
      if (wr_csr && hwdata_i[`TS_CSR_SWT])
        sw_pend <= 1'b1;
      else if (wait_exit && op == trigger_sequencer_pkg::OP_CTRL && arg == 4'h1)
        sw_pend <= 1'b0;
    end
  end
  // Interrupt pulses
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prog_irq_o <= 4'h0;
      step_irq_o <= 1'b0;
      watchdog_irq_o <= 1'b0;
    end
    else
    begin
      prog_irq_o <= (exec_now && op == trigger_sequencer_pkg::OP_IRQ) ?
        (4'h1 << arg[1:0]) : 4'h0;
      step_irq_o <= step_done && single_step_enable;
      watchdog_irq_o <= wdt_expire;
    end
  end
  // Trigger outputs: toggle or fixed-width pulse
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !sequencer_enable)
    begin
      trig_level <= 16'h0000;
      pulse_mask <= 16'h0000;
      pulse_cnt <= 4'h0;
    end
    else if (trig_load && trigger_toggle_mode)
      trig_level <= trig_level ^ sel_bit;
    else if (trig_load)
    begin
      trig_level <= trig_level | sel_bit;
      pulse_mask <= pulse_mask | sel_bit;
      pulse_cnt <= pulse_width_code;
    end
    else if (tick && pulse_mask != 16'h0000)
    begin
      if (pulse_cnt == 4'h0)
      begin
        trig_level <= trig_level & ~pulse_mask;
        pulse_mask <= 16'h0000;
      end
      else
        pulse_cnt <= pulse_cnt - 4'h1;
    end
  end
  assign {cmp_trig_o, pwm_trig_o, adc_trig_o, ic_trig_o, oc_trig_o, wdt_trig_o} =
    trig_level;

  step_queue_mem u_queue
  (
    .clk_sys_i(clk_sys_i),
    .q(q)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_enable_gates_engine: assert property (!sequencer_enable |=>
    state == trigger_sequencer_pkg::ST_IDLE) else $error("engine ran while disabled");
  a_idle_freezes_ptr: assert property (halt && $past(halt) |-> $stable(step_ptr))
    else $error("pointer moved in idle halt");
  a_toggle_flips_out: assert property (trig_load && trigger_toggle_mode |=>
    trig_level != $past(trig_level)) else $error("toggle step left outputs");
  a_pulse_load_width: assert property (trig_load && !trigger_toggle_mode |=>
    pulse_mask != 16'h0000 && pulse_cnt == $past(pulse_width_code))
    else $error("pulse not started with width code");
  a_pulse_end_clear: assert property (tick && pulse_cnt == 4'h0 && !trig_load &&
    pulse_mask != 16'h0000 |=> pulse_mask == 16'h0000) else $error("pulse overran");
  a_swt_sets_pend: assert property (wr_csr && hwdata_i[`TS_CSR_SWT] |=> sw_pend)
    else $error("software trigger lost");
  a_single_step_irq: assert property (step_done && single_step_enable |=>
    step_irq_o && !sequencer_run) else $error("single step irq missing");
  a_wdt_flag_irq: assert property (wdt_expire |=> watchdog_timeout_flag &&
    watchdog_irq_o ##1 !watchdog_irq_o) else $error("watchdog expiry not reported");
  a_csr_unused_zero: assert property (ph_rd && ph_addr == `TS_OFF_CSR |->
    hrdata_o[14] == 1'b0 && hrdata_o[11] == 1'b0 && hrdata_o[5:2] == 4'h0)
    else $error("unimplemented bits nonzero");
  a_run_stop_idle: assert property (!sequencer_run |=>
    state == trigger_sequencer_pkg::ST_IDLE) else $error("ran without run bit");
  c_trig_pulse: cover property (trig_load ##[1:20] pulse_mask == 16'h0000);
  c_wdt_expire: cover property (wdt_expire);
  c_loop_jump: cover property (exec_now && op == trigger_sequencer_pkg::OP_LOOP && take_loop);
  c_swt_wait: cover property (wait_exit && op == trigger_sequencer_pkg::OP_CTRL);
endmodule

/* rtl/trigger_sequencer_consts.svh */
// Register offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef TRIGGER_SEQUENCER_CONSTS_SVH
`define TRIGGER_SEQUENCER_CONSTS_SVH
// ==========================================================================
// Register byte offsets
`define TS_OFF_CSR 8'h00
`define TS_OFF_CTRL 8'h04
`define TS_OFF_SD_LIM 8'h08
`define TS_OFF_T0_LIM 8'h0C
`define TS_OFF_T1_LIM 8'h10
`define TS_OFF_C0_LIM 8'h14
`define TS_OFF_C1_LIM 8'h18
`define TS_OFF_STATUS 8'h1C
`define TS_QUEUE_BASE_SEL 3'h1
// ==========================================================================
// Control/status field positions
`define TS_CSR_EN 15
`define TS_CSR_IDLE_STOP 13
`define TS_CSR_TOGGLE 12
`define TS_CSR_SWT 10
`define TS_CSR_SSTEP 9
`define TS_CSR_VIS 8
`define TS_CSR_RUN 7
`define TS_CSR_WDTO 6
`define TS_CSR_ITM_HI 1
`define TS_CSR_ITM_LO 0
// ==========================================================================
// Control register field positions
`define TS_CTRL_CLK_HI 15
`define TS_CTRL_CLK_LO 13
`define TS_CTRL_DIV_HI 12
`define TS_CTRL_DIV_LO 8
`define TS_CTRL_PWD_HI 7
`define TS_CTRL_PWD_LO 4
`define TS_CTRL_WDT_HI 2
`define TS_CTRL_WDT_LO 0
// ==========================================================================
// Reset values and timing counts
`define TS_RST_CSR 16'h0000
`define TS_RST_CTRL 16'h0000
`define TS_RST_LIMIT 16'h0000
`define TS_WDT_SHIFT_BASE 4'h2
`endif

/* rtl/trigger_sequencer_pkg.sv */
// Types shared by the trigger sequencer modules
package trigger_sequencer_pkg;
  // Sequencer states, one-hot
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DELAY = 5'b10000
  } seq_state_t;
  // Step command opcodes, upper nibble of a step
  typedef enum logic [3:0]
  {
    OP_CTRL = 4'h0,
    OP_WAIT_HIGH = 4'h1,
    OP_WAIT_LOW = 4'h2,
    OP_TRIG = 4'h3,
    OP_IRQ = 4'h4,
    OP_LOOP = 4'h5,
    OP_JUMP = 4'h6
  } step_op_t;
endpackage

/* sim/periph_model.sv */
// Peripherals that feed trigger levels to the sequencer
`timescale 1ns/1ps
module periph_model
(
  input wire logic clk_sys_i,
  input wire logic [15:0] lvl_i,
  output logic adc_o,
  output logic [2:0] pwm_o,
  output logic [3:0] oc_o,
  output logic [3:0] ic_o,
  output logic [2:0] cmp_o,
  output logic ext_o
);
  // Trigger levels launched just after the edge
  always_ff @(posedge clk_sys_i)
    {ext_o, cmp_o, ic_o, oc_o, pwm_o, adc_o} <= lvl_i;
endmodule

/* sim/tb_top.sv */
// Testbench of the trigger sequencer
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i, rst_i, hwrite, hrdy, step_irq, wdt_irq, adc, ext, idle;
  logic [1:0] htrans;
  logic [2:0] pwm, cmp;
  logic [3:0] oc, ic, oc_out, irq;
  logic [15:0] lvl;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int fail_count, samples_checked, cyc, n, m, p, w;
  // Address, write data, value read back
  logic [15:0] rows [6][3] = '{'{16'h00, 16'h7FFF, 16'h3783}, '{16'h00, 16'h0000, 16'h0400},
    '{16'h08, 16'h1234, 16'h1234}, '{16'h04, 16'hFFFF, 16'hFFF7},
    '{16'h40, 16'hFFFF, 16'h0000}, '{16'h20, 16'h01FF, 16'h00FF}};
  periph_model pm (.clk_sys_i(clk_sys_i), .lvl_i(lvl), .adc_o(adc), .pwm_o(pwm),
    .oc_o(oc), .ic_o(ic), .cmp_o(cmp), .ext_o(ext));
  trigger_sequencer uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(), .idle_i(idle), .adc_trig_i(adc), .pwm_trig_i(pwm), .oc_trig_i(oc),
    .ic_trig_i(ic), .cmp_trig_i(cmp), .external_interrupt_line_i(ext), .wdt_trig_o(),
    .oc_trig_o(oc_out), .ic_trig_o(), .adc_trig_o(), .pwm_trig_o(), .cmp_trig_o(),
    .prog_irq_o(irq), .step_irq_o(step_irq), .watchdog_irq_o(wdt_irq));
  // ==========================================================
  // Bus, compare and closing tasks
  task bus(input [7:0] a, input [31:0] wd, input wr);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task chk(input string s, input [15:0] e, input [31:0] g);
    samples_checked++;
    if (g !== {16'h0000, e})
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Counts output activity over k cycles
  task mon(input int k);
    n = 0;
    m = 0;
    p = 0;
    w = 0;
    for (int i = 1; i <= k; i++)
    begin
      @(posedge clk_sys_i);
      n += oc_out[0];
      m += step_irq;
      p += irq[1];
      if (wdt_irq === 1'b1)
        w = i;
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Clock and hang guard
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    {htrans, hwrite, haddr, hwdata, lvl, idle} = '0;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(rows[i][0][7:0], {16'h0000, rows[i][1]}, 1'b1);
      bus(rows[i][0][7:0], 32'h0, 1'b0);
      chk("register table", rows[i][2], rd);
    end
    $display("register table done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(8'h00, 32'h0, 1'b0);
    chk("csr after reset", 16'h0000, rd);
    bus(8'h20, 32'h31, 1'b1);
    bus(8'h24, 32'h31, 1'b1);
    bus(8'h28, 32'h01, 1'b1);
    bus(8'h2C, 32'h1F, 1'b1);
    bus(8'h30, 32'h41, 1'b1);
    bus(8'h34, 32'h62, 1'b1); // Jump back to the software-trigger wait
    bus(8'h04, 32'h20, 1'b1);
    bus(8'h00, 32'h8280, 1'b1);
    mon(40);
    chk("pulse cycles", 16'h0003, n);
    chk("step irq", 16'h0001, m);
    bus(8'h00, 32'h9280, 1'b1);
    mon(40);
    chk("toggle level", 16'h0001, oc_out[0]);
    $display("trigger steps done");
    bus(8'h04, 32'h21, 1'b1);
    bus(8'h00, 32'h8080, 1'b1);
    mon(40);
    chk("watchdog time", 16'h0001, w >= 9 && w <= 13);
    bus(8'h00, 32'h0, 1'b0);
    chk("watchdog flag", 16'h8040, rd);
    bus(8'h00, 32'h8000, 1'b1);
    bus(8'h00, 32'h0, 1'b0);
    chk("flag cleared", 16'h8000, rd);
    $display("watchdog done");
    bus(8'h04, 32'h20, 1'b1);
    bus(8'h00, 32'h8481, 1'b1);
    mon(20);
    chk("irq before edge", 16'h0000, p);
    lvl <= 16'h8000;
    mon(20);
    chk("irq after edge", 16'h0001, p);
    $display("input wait done");
    // Idle halt holds a pending software trigger until idle ends
    idle <= 1'b1;
    bus(8'h00, 32'hA480, 1'b1);
    mon(10);
    bus(8'h00, 32'h0, 1'b0);
    chk("idle halt", 16'hA480, rd);
    idle <= 1'b0;
    mon(10);
    bus(8'h00, 32'h0, 1'b0);
    chk("trigger consumed", 16'hA080, rd);
    $display("idle halt done");
    stop_test();
  end
endmodule
